// ---- pkg/adc_seq_pkg.sv ----
/*
 Shared constants and types for the four-channel converter sequencer.
 Assumes one register bank behind a four-wire serial link; the byte, frame and count widths below
*/
// Behaviour
// (RULE_01) sequence register fields 7:6 to 1:0 name first to fourth channel read out
// (RULE_02) host programs each channel address exactly once in the sequence register
// (RULE_03) sequence fields reset to 00, 01, 10, 11: ascending order
// (RULE_04) every result is sixteen bits: four status bits, twelve value bits
// (RULE_05) result bits 15:14 return that result's channel address
// (RULE_06) result bit 13 is 0 for chip select trigger, 1 for convert strobe
// (RULE_07) result bit 12 set when the strobe sample came before the chip select start
// (RULE_08) result bits 11:0 carry the converter value, bit 11 most significant
// (RULE_09) after reset the device is configuring, registers writable and readable
// (RULE_10) state code 011 in the operating register enters measurement
// (RULE_11) measuring, conversion starts on the configured falling edge after tracking
// (RULE_12) host returns to configuration before changing any setting
// (RULE_13) configuring, frames are write address, write data, read address
// (RULE_14) register named by read address is the first output byte of next frame
// (RULE_15) write to an undefined address changes nothing
// (RULE_16) host writes 83h at address 00h to measure with tracking
// (RULE_17) measuring, frames are address/data pairs, no read address
// (RULE_18) measuring, next chip select fall ends tracking and samples all inputs
// (RULE_19) four result words go out in programmed order during four pairs
// (RULE_20) operating data 00h is a no-operation, 80h restarts tracking
// (RULE_21) operating data 40h enters power-down, later 80h leaves it and tracks
// (RULE_22) state code 010 returns to configuration, other registers to defaults
// (RULE_23) source bit 0 samples on chip select fall, 1 on convert strobe fall
// (RULE_24) bytes and words travel most significant bit first
// (RULE_25) clocks beyond the fourth word return undefined data
package adc_seq_pkg;
   localparam int NUM_CH = 4;
   localparam int CH_W = 2;
   localparam int ADC_W = 12;
   localparam int WORD_W = 16;
   localparam int FRAME_W = 64;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 3;
   localparam logic [7:0] ADDR_OPERATING = 8'h00;
   localparam logic [7:0] ADDR_IDENTITY = 8'h02;
   localparam logic [7:0] ADDR_CONFIG = 8'h06;
   localparam logic [7:0] ADDR_GAIN0 = 8'h07;
   localparam logic [7:0] ADDR_CHAN_PD = 8'h0b;
   localparam logic [7:0] ADDR_CHANNEL_SEQUENCE = 8'h0c;
   localparam int OP_TRACK_BIT = 7;
   localparam int OP_PD_BIT = 6;
   localparam logic [2:0] CODE_MEAS = 3'h3;
   localparam logic [2:0] CODE_CFG = 3'h2;
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam int CFG_SOURCE_BIT = 4;
   localparam logic [7:0] RST_OPERATING = 8'h02;
   localparam logic [7:0] RST_CONFIG = 8'ha0;
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [7:0] RST_CHAN_PD = 8'h00;
   localparam logic [7:0] RST_SEQUENCE = 8'h1b;
   localparam logic [3:0] IDX_WDATA = 4'h1;
   localparam logic [3:0] IDX_RADDR = 4'h2;
   typedef enum logic [1:0] {
      ST_CFG = 2'b01,
      ST_MEAS = 2'b10
   } op_state_type;
endpackage : adc_seq_pkg

// ---- pkg/spi_link_if.sv ----
/*
 Carrier between the serial-clock shifter and the register core.
 Assumes the first sclk rise comes at least three core clocks after chip select
 falls, since tx_frame settles only once the synced chip select is low.
*/
interface spi_link_if;
   import adc_seq_pkg::*;
   logic [CNT_W-1:0] byte_gray;
   logic [BYTE_W-1:0] rx_byte;
   logic [FRAME_W-1:0] tx_frame;
   modport link (output byte_gray, output rx_byte, input tx_frame);
   modport core (input byte_gray, input rx_byte, output tx_frame);
endinterface : spi_link_if

// ---- verilog/spi_link.sv ----
/*
 Serial shifter on the link clock: receives bytes, sends the 64-bit frame.
 Assumes clock phase 1: the device launches on the rising edge, both sides
 sample on the falling edge; chip select high clears the counters and data out, the received byte is held.
*/
module spi_link (
   input wire logic sclk_i,
   input wire logic chip_select_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   spi_link_if.link lnk
);
   import adc_seq_pkg::*;

   logic [6:0] bit_cnt_q, bit_cnt_d;
   logic [CNT_W-1:0] bin_q, bin_d, gray_q, gray_d;
   logic [BYTE_W-2:0] rx_sh_q, rx_sh_d;
   logic [BYTE_W-1:0] rx_byte_q, rx_byte_d;
   logic miso_q, miso_d;
   logic oe_q;
   logic [5:0] tx_idx;

   always_comb begin
      bit_cnt_d = (&bit_cnt_q) ? bit_cnt_q : bit_cnt_q + 7'h01;
      rx_sh_d = {rx_sh_q[BYTE_W-3:0], mosi_i}; // RULE_24
      rx_byte_d = rx_byte_q;
      bin_d = bin_q;
      if (&bit_cnt_q[2:0]) begin
         rx_byte_d = {rx_sh_q, mosi_i};
         bin_d = bin_q + 3'h1;
      end
      gray_d = bin_d ^ (bin_d >> 1);
      tx_idx = 6'(FRAME_W - 1) - bit_cnt_q[5:0];
      // beyond the last word the line just idles low
      miso_d = bit_cnt_q[6] ? 1'b0 : lnk.tx_frame[tx_idx]; // RULE_25 RULE_24
   end

   // frame counters die with chip select, so no edge after the frame is needed
   always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         bit_cnt_q <= 7'h00;
         bin_q <= 3'h0;
         gray_q <= 3'h0;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         bin_q <= bin_d;
         gray_q <= gray_d;
      end
   end

   // held past the frame end until the core has taken the last byte
   always_ff @(negedge sclk_i) begin
      rx_sh_q <= rx_sh_d;
      rx_byte_q <= rx_byte_d;
   end

   always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         miso_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         miso_q <= miso_d;
         oe_q <= 1'b1;
      end
   end

   assign miso_o = miso_q;
   assign miso_oe_o = oe_q;
   assign lnk.byte_gray = gray_q;
   assign lnk.rx_byte = rx_byte_q;
endmodule : spi_link

// ---- verilog/current_adc_spi_sequencer.sv ----
/*
 Register core and measurement sequencer of the four-channel converter.
 Assumes converter values on adc_data_i are in the mclk_i domain and stable
 around the sampling edge; the serial link runs on sclk_i.
*/
module current_adc_spi_sequencer #(
   parameter logic [7:0] IDENTITY_VALUE = 8'h5a // arbitrary value
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic chip_select_n_i,
   input wire logic mosi_i,
   input wire logic convert_strobe_n_i,
   input wire logic [adc_seq_pkg::NUM_CH*adc_seq_pkg::ADC_W-1:0] adc_data_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic track_o,
   output logic sample_o,
   output logic power_down_o,
   output logic meas_state_o,
   output logic [7:0] config_o,
   output logic [adc_seq_pkg::NUM_CH*8-1:0] gain_o,
   output logic [3:0] chan_pd_o
);
   import adc_seq_pkg::*;

   spi_link_if lnk ();

   spi_link u_link (
      .sclk_i(sclk_i),
      .chip_select_n_i(chip_select_n_i),
      .mosi_i(mosi_i),
      .miso_o(miso_o),
      .miso_oe_o(miso_oe_o),
      .lnk(lnk.link)
   );

   // pin and cross-domain synchronisers
   logic cs_s1, cs_s2, cs_s3;
   logic cv_s1, cv_s2, cv_s3;
   logic [CNT_W-1:0] g_s1, g_s2;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         cv_s1 <= 1'b1;
         cv_s2 <= 1'b1;
         cv_s3 <= 1'b1;
         g_s1 <= 3'h0;
         g_s2 <= 3'h0;
      end else begin
         cs_s1 <= chip_select_n_i;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         cv_s1 <= convert_strobe_n_i;
         cv_s2 <= cv_s1;
         cv_s3 <= cv_s2;
         g_s1 <= lnk.byte_gray;
         g_s2 <= g_s1;
      end
   end

   logic cs_fall, cv_fall;
   logic [CNT_W-1:0] g_bin;
   logic byte_new;
   logic [BYTE_W-1:0] rx_byte;

   assign cs_fall = cs_s3 & ~cs_s2;
   assign cv_fall = cv_s3 & ~cv_s2;
   assign g_bin = {g_s2[2], g_s2[2] ^ g_s2[1], g_s2[2] ^ g_s2[1] ^ g_s2[0]};
   // byte register is stable for a whole byte time once the count has moved
   assign rx_byte = lnk.rx_byte;

   // core state
   op_state_type state_q, state_d;
   logic [7:0] operating_q, operating_d;
   logic [7:0] config_q, config_d;
   logic [NUM_CH*8-1:0] gain_q, gain_d;
   logic [7:0] chan_pd_q, chan_pd_d;
   logic [7:0] seq_q, seq_d;
   logic [7:0] read_q, read_d;
   logic [7:0] wa_q, wa_d;
   logic [3:0] byte_idx_q, byte_idx_d;
   logic [CNT_W-1:0] done_q, done_d;
   logic [NUM_CH*ADC_W-1:0] held_q, held_d;
   logic early_q, early_d;
   logic sample_q, sample_d;
   logic [FRAME_W-1:0] tx_q, tx_d;
   logic [FRAME_W-1:0] words_c;
   logic [1:0] gsel;
   logic src;
   logic [CH_W-1:0] ch;
   logic [ADC_W-1:0] val;

   // only a one-step advance is a byte: the count's clear at deselect must not pass for one
   assign byte_new = (g_bin == CNT_W'(done_q + 3'h1)) && !cs_s2;
   assign gsel = 2'(wa_q - ADDR_GAIN0);
   assign src = config_q[CFG_SOURCE_BIT];

   function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                           input logic [7:0] op,
                                           input logic [7:0] cfg,
                                           input logic [NUM_CH*8-1:0] gain,
                                           input logic [7:0] pd,
                                           input logic [7:0] seq);
      logic [7:0] r;
      logic [1:0] gi;
      r = 8'h00;
      gi = 2'(addr - ADDR_GAIN0);
      if (addr == ADDR_OPERATING) begin
         r = op;
      end else if (addr == ADDR_IDENTITY) begin
         r = IDENTITY_VALUE;
      end else if (addr == ADDR_CONFIG) begin
         r = cfg;
      end else if (addr >= ADDR_GAIN0 && addr < ADDR_CHAN_PD) begin
         r = gain[gi*8 +: 8];
      end else if (addr == ADDR_CHAN_PD) begin
         r = pd;
      end else if (addr == ADDR_CHANNEL_SEQUENCE) begin
         r = seq;
      end
      return r;
   endfunction : reg_read

   // result words in the programmed order, first word in the top bits
   always_comb begin
      words_c = '0;
      ch = 2'h0;
      val = '0;
      for (int k = 0; k < NUM_CH; k++) begin
         ch = seq_q[(NUM_CH-1-k)*CH_W +: CH_W]; // RULE_01
         // strobe source uses the captured set; chip select uses the live one
         val = src ? held_q[ch*ADC_W +: ADC_W] : adc_data_i[ch*ADC_W +: ADC_W];
         // RULE_04 RULE_05 RULE_06 RULE_07 RULE_08
         words_c[(NUM_CH-1-k)*WORD_W +: WORD_W] = {ch, src, src & early_q, val};
      end
   end

   always_comb begin
      state_d = state_q;
      operating_d = operating_q;
      config_d = config_q;
      gain_d = gain_q;
      chan_pd_d = chan_pd_q;
      seq_d = seq_q;
      read_d = read_q;
      wa_d = wa_q;
      byte_idx_d = byte_idx_q;
      done_d = done_q;
      held_d = held_q;
      early_d = early_q;
      sample_d = 1'b0;
      tx_d = tx_q;
      if (byte_new) begin
         done_d = done_q + 3'h1;
         byte_idx_d = (&byte_idx_q) ? byte_idx_q : byte_idx_q + 4'h1;
         unique case (state_q)
            ST_CFG: begin
               // RULE_13 RULE_09
               if (byte_idx_q == 4'h0) begin
                  wa_d = rx_byte;
               end else if (byte_idx_q == IDX_WDATA) begin
                  if (wa_q == ADDR_OPERATING) begin
                     operating_d = rx_byte;
                     if (rx_byte[2:0] == CODE_MEAS) begin
                        state_d = ST_MEAS; // RULE_10
                     end
                  end else if (wa_q == ADDR_CONFIG) begin
                     config_d = rx_byte;
                  end else if (wa_q >= ADDR_GAIN0 && wa_q < ADDR_CHAN_PD) begin
                     gain_d[gsel*8 +: 8] = rx_byte;
                  end else if (wa_q == ADDR_CHAN_PD) begin
                     chan_pd_d = rx_byte;
                  end else if (wa_q == ADDR_CHANNEL_SEQUENCE) begin
                     seq_d = rx_byte;
                  end
                  // anything else, identity included, is dropped: RULE_15
               end else if (byte_idx_q == IDX_RADDR) begin
                  // RULE_14
                  read_d = reg_read(rx_byte, operating_q, config_q, gain_q,
                                    chan_pd_q, seq_q);
               end
            end
            ST_MEAS: begin
               // only the operating register is decoded while measuring
               if (!byte_idx_q[0]) begin
                  wa_d = rx_byte; // RULE_17
               end else if (wa_q == ADDR_OPERATING) begin
                  if (rx_byte == OP_NOP) begin
                     operating_d = operating_q; // RULE_20
                  end else if (rx_byte[2:0] == CODE_CFG) begin
                     // RULE_22
                     state_d = ST_CFG;
                     operating_d = rx_byte;
                     config_d = RST_CONFIG;
                     gain_d = {NUM_CH{RST_GAIN}};
                     chan_pd_d = RST_CHAN_PD;
                     seq_d = RST_SEQUENCE;
                  end else begin
                     // 80h tracks, 40h powers down; state code is kept
                     operating_d = {rx_byte[7:3], CODE_MEAS}; // RULE_20 RULE_21
                  end
               end
            end
         endcase
      end else if (cs_s2) begin
         byte_idx_d = 4'h0;
         done_d = 3'h0;
      end
      // sampling only after tracking and never while powered down
      if (state_q == ST_MEAS && operating_q[OP_TRACK_BIT] && !operating_q[OP_PD_BIT]
          && ((!src && cs_fall) || (src && cv_fall))) begin // RULE_11 RULE_23
         sample_d = 1'b1;
         operating_d[OP_TRACK_BIT] = 1'b0; // RULE_18
         if (src) begin
            held_d = adc_data_i;
            early_d = cs_s2; // RULE_07
         end else begin
            early_d = 1'b0;
         end
      end
      // the link reads the frame during chip select low, so freeze it then
      if (cs_s2) begin
         tx_d = (state_q == ST_MEAS) ? words_c : {read_q, 56'h0}; // RULE_19 RULE_14
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_q <= ST_CFG; // RULE_09
         operating_q <= RST_OPERATING;
         config_q <= RST_CONFIG;
         gain_q <= {NUM_CH{RST_GAIN}};
         chan_pd_q <= RST_CHAN_PD;
         seq_q <= RST_SEQUENCE; // RULE_03
         read_q <= 8'h00;
         wa_q <= 8'h00;
         byte_idx_q <= 4'h0;
         done_q <= 3'h0;
         held_q <= '0;
         early_q <= 1'b0;
         sample_q <= 1'b0;
         tx_q <= '0;
      end else begin
         state_q <= state_d;
         operating_q <= operating_d;
         config_q <= config_d;
         gain_q <= gain_d;
         chan_pd_q <= chan_pd_d;
         seq_q <= seq_d;
         read_q <= read_d;
         wa_q <= wa_d;
         byte_idx_q <= byte_idx_d;
         done_q <= done_d;
         held_q <= held_d;
         early_q <= early_d;
         sample_q <= sample_d;
         tx_q <= tx_d;
      end
   end

   assign lnk.tx_frame = tx_q;
   assign track_o = operating_q[OP_TRACK_BIT];
   assign power_down_o = operating_q[OP_PD_BIT]; // RULE_21
   assign sample_o = sample_q;
   assign meas_state_o = state_q[1];
   assign config_o = config_q;
   assign gain_o = gain_q;
   assign chan_pd_o = chan_pd_q[3:0];

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_seq_default: assert property ($fell(reset_i) |-> seq_q == RST_SEQUENCE) // RULE_03
      else $error("sequence register not at ascending default");

   a_meas_entry: assert property (state_q == ST_CFG && byte_new && byte_idx_q == IDX_WDATA // RULE_10
      && wa_q == ADDR_OPERATING && rx_byte[2:0] == CODE_MEAS |=> state_q == ST_MEAS)
      else $error("state code 011 did not enter measurement");

   a_undef_write: assert property (state_q == ST_CFG && byte_new && byte_idx_q == IDX_WDATA // RULE_15
      && wa_q == 8'h01 |=> $stable(config_q) && $stable(seq_q) && $stable(operating_q))
      else $error("undefined write address changed a register");

   a_cfg_return: assert property (state_q == ST_MEAS && byte_new && byte_idx_q[0] // RULE_22
      && wa_q == ADDR_OPERATING && rx_byte != OP_NOP && rx_byte[2:0] == CODE_CFG
      |=> state_q == ST_CFG && seq_q == RST_SEQUENCE && config_q == RST_CONFIG)
      else $error("return to configuration did not restore defaults");

   a_nop_write: assert property (state_q == ST_MEAS && byte_new && byte_idx_q[0] // RULE_20
      && wa_q == ADDR_OPERATING && rx_byte == OP_NOP && !cs_fall && !cv_fall
      |=> $stable(operating_q) && state_q == ST_MEAS)
      else $error("no-operation write changed the operating register");

   a_pd_enter: assert property (state_q == ST_MEAS && byte_new && byte_idx_q[0] // RULE_21
      && wa_q == ADDR_OPERATING && rx_byte == 8'h40 |=> power_down_o && !track_o)
      else $error("power-down write not taken");

   a_track_end: assert property (sample_q |-> !track_o ##1 !sample_q) // RULE_18
      else $error("tracking still on after sampling");

   a_cs_sample: assert property (state_q == ST_MEAS && track_o && !power_down_o && !src // RULE_11
      && cs_fall |=> sample_q)
      else $error("chip select fall did not sample");

   a_read_back: assert property (state_q == ST_CFG && byte_new && byte_idx_q == IDX_RADDR // RULE_14
      && rx_byte == ADDR_CHANNEL_SEQUENCE |=> read_q == $past(seq_q))
      else $error("read address did not return the register");

   a_word_channel: assert property (cs_s2 && state_q == ST_MEAS // RULE_05
      |=> tx_q[FRAME_W-1 -: CH_W] == $past(seq_q[7:6]))
      else $error("first word carries the wrong channel address");

   a_word_trig: assert property (cs_s2 && state_q == ST_MEAS && !src // RULE_06
      |=> !tx_q[FRAME_W-3] && !tx_q[FRAME_W-4])
      else $error("trigger status bits wrong for chip select source");
endmodule : current_adc_spi_sequencer

// ---- test/spi_host_model.sv ----
/*
 Behavioural host of the serial link: chip select, serial clock, data out.
 Assumes the device launches on rising sclk; host and device sample on falling sclk.
*/
module spi_host_model (
   input wire logic miso_i,
   input wire logic miso_oe_i,
   output logic sclk_o,
   output logic chip_select_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 16;
   // a deselect edge at power-up clears the link, which has no reset of its own
   initial begin
      sclk_o = 1'b0;
      chip_select_n_o = 1'b0;
      mosi_o = 1'b0;
      #1;
      chip_select_n_o = 1'b1;
   end
   // stretch stalls between bytes with the clock standing still
   task automatic xfer(input int nbits, input int stretch, input logic [63:0] tx,
                       output logic [63:0] rx);
      int i;
      rx = '0;
      // off the core clock edge, and a full period before the first sclk rise
      #3;
      chip_select_n_o = 1'b0;
      #(2 * HALF);
      for (i = 0; i < nbits; i++) begin
         sclk_o = 1'b1;
         mosi_o = tx[63-i];
         #(HALF);
         sclk_o = 1'b0;
         // an undriven line reads as the opposite level, never as a match
         rx[63-i] = miso_oe_i ? miso_i : ~miso_i;
         #(HALF);
         if (i % 8 == 7) begin
            #(stretch);
         end
      end
      #48;
      chip_select_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #100;
   endtask : xfer
endmodule : spi_host_model

// ---- test/current_adc_spi_sequencer_test.sv ----
/*
 Self-checking bench of the sequencer: register frames, measurement frames,
 power-down, return to configuration and strobe sampling.
 Assumes spi_host_model plays the host on the serial link.
*/
`define CHECK(got, exp) begin \
   num_checks++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end

module current_adc_spi_sequencer_test;
   timeunit 1ns;
   timeprecision 100ps;
   import adc_seq_pkg::*;
   localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
   localparam int LIMIT = 20000; // a few times the expected run
   logic mclk;
   logic reset;
   logic strobe_n;
   logic [NUM_CH*ADC_W-1:0] adc;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic track;
   logic sample;
   logic pd;
   logic meas;
   logic [7:0] cfg;
   logic [NUM_CH*8-1:0] gain;
   logic [3:0] chpd;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   int sample_cnt = 0;

   current_adc_spi_sequencer #(.IDENTITY_VALUE(ID_VAL)) u_current_adc_spi_sequencer (
      .mclk_i(mclk), .reset_i(reset), .sclk_i(sclk), .chip_select_n_i(cs_n),
      .mosi_i(mosi), .convert_strobe_n_i(strobe_n), .adc_data_i(adc), .miso_o(miso),
      .miso_oe_o(miso_oe), .track_o(track), .sample_o(sample), .power_down_o(pd),
      .meas_state_o(meas), .config_o(cfg), .gain_o(gain), .chan_pd_o(chpd));
   spi_host_model u_spi_host_model (.miso_i(miso), .miso_oe_i(miso_oe), .sclk_o(sclk),
      .chip_select_n_o(cs_n), .mosi_o(mosi));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   always @(posedge mclk) begin
      cycles++;
      if (sample === 1'b1) begin
         sample_cnt++;
      end
      if (cycles == LIMIT) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step

   task automatic frame(input int nbits, input int stretch, input logic [63:0] tx,
                        output logic [63:0] rx);
      u_spi_host_model.xfer(nbits, stretch, tx, rx);
      step(8);
   endtask : frame

   task automatic cfg_frame(input logic [7:0] wa, input logic [7:0] wd,
                            input logic [7:0] ra, output logic [7:0] first);
      logic [63:0] rx;
      frame(24, 0, {wa, wd, ra, 40'h0}, rx);
      first = rx[63:56];
   endtask : cfg_frame

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      cfg_frame(a, d, 8'h00, dummy);
   endtask : write_reg

   // 01h is an undefined address, so the dummy writes disturb nothing
   task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
      cfg_frame(8'h01, 8'h00, a, v);
      cfg_frame(8'h01, 8'h00, 8'h00, v);
   endtask : read_reg

   task automatic check_words(input logic [63:0] rx, input logic [7:0] seq,
                              input logic src, input logic [47:0] v);
      int k;
      logic [1:0] ch;
      for (k = 0; k < 4; k++) begin
         ch = seq[7-2*k -: 2];
         `CHECK(rx[63-16*k -: 16], {ch, src, src, v[12*ch +: 12]})
      end
   endtask : check_words

   task automatic test_defaults();
      logic [7:0] v;
      read_reg(ADDR_CHANNEL_SEQUENCE, v);
      `CHECK(v, 8'h1b)
      read_reg(ADDR_IDENTITY, v);
      `CHECK(v, ID_VAL)
      `CHECK({cfg, meas}, {RST_CONFIG, 1'b0})
      $display("test defaults done");
   endtask : test_defaults

   task automatic test_unmapped();
      logic [7:0] v;
      write_reg(8'h01, 8'hff);
      write_reg(ADDR_IDENTITY, 8'h00);
      read_reg(ADDR_CHANNEL_SEQUENCE, v);
      `CHECK(v, 8'h1b)
      read_reg(ADDR_IDENTITY, v);
      `CHECK(v, ID_VAL)
      `CHECK(cfg, RST_CONFIG)
      $display("test unmapped done");
   endtask : test_unmapped

   task automatic test_order();
      logic [7:0] v;
      write_reg(ADDR_CHANNEL_SEQUENCE, 8'he1);
      read_reg(ADDR_CHANNEL_SEQUENCE, v);
      `CHECK(v, 8'he1)
      write_reg(8'h08, 8'h25);
      write_reg(ADDR_CHAN_PD, 8'h05);
      `CHECK({gain, chpd}, {32'h0000_2500, 4'h5})
      read_reg(8'h08, v);
      `CHECK(v, 8'h25)
      $display("test order done");
   endtask : test_order

   task automatic test_measure();
      logic [63:0] rx;
      int n;
      adc = {12'habc, 12'h789, 12'h456, 12'h123};
      write_reg(ADDR_OPERATING, 8'h83);
      `CHECK({meas, track}, 2'b11)
      n = sample_cnt;
      frame(64, 0, 64'h80, rx);
      `CHECK(sample_cnt, n + 1)
      check_words(rx, 8'he1, 1'b0, adc);
      `CHECK(track, 1'b1)
      frame(16, 0, 64'h0, rx);
      `CHECK({sample_cnt == n + 2, track}, 2'b10)
      frame(16, 0, 64'h0, rx);
      `CHECK(sample_cnt, n + 2)
      $display("test measure done");
   endtask : test_measure

   task automatic test_power_down();
      logic [63:0] rx;
      int n;
      frame(16, 0, {8'h00, 8'h40, 48'h0}, rx);
      `CHECK({pd, track, meas}, 3'b101)
      n = sample_cnt;
      frame(16, 0, {8'h00, 8'h80, 48'h0}, rx);
      `CHECK({pd, track, meas}, 3'b011)
      `CHECK(sample_cnt, n)
      $display("test power down done");
   endtask : test_power_down

   task automatic test_return_cfg();
      logic [63:0] rx;
      logic [7:0] v;
      frame(16, 0, {8'h00, 8'h02, 48'h0}, rx);
      `CHECK(meas, 1'b0)
      `CHECK({gain, chpd}, 36'h0)
      read_reg(ADDR_CHANNEL_SEQUENCE, v);
      `CHECK(v, 8'h1b)
      read_reg(ADDR_OPERATING, v);
      `CHECK(v, 8'h02)
      $display("test return to configuration done");
   endtask : test_return_cfg

   task automatic test_strobe();
      logic [63:0] rx;
      logic [47:0] held;
      int n;
      write_reg(ADDR_CONFIG, RST_CONFIG | 8'h10);
      `CHECK(cfg, RST_CONFIG | 8'h10)
      write_reg(ADDR_OPERATING, 8'h83);
      adc = {12'h0f1, 12'h802, 12'h7ff, 12'h000};
      held = adc;
      n = sample_cnt;
      strobe_n = 1'b0;
      step(3);
      strobe_n = 1'b1;
      step(8);
      `CHECK(sample_cnt, n + 1)
      // new live values prove the words carry the strobe capture
      adc = ~adc;
      frame(64, 40, 64'h80, rx);
      `CHECK(sample_cnt, n + 1)
      check_words(rx, 8'h1b, 1'b1, held);
      $display("test strobe done");
   endtask : test_strobe

   initial begin
      reset = 1'b1;
      strobe_n = 1'b1;
      adc = '0;
      step(4);
      reset = 1'b0;
      step(4);
      test_defaults();
      test_unmapped();
      test_order();
      test_measure();
      test_power_down();
      test_return_cfg();
      test_strobe();
      complete_run();
   end
endmodule : current_adc_spi_sequencer_test
